/* File: include/lpass_pkg.sv */
// Constants for the linear pixel array scan sequencer.
// Assumes a single 125 MHz system clock; the scan clock arrives as a pin.
package lpass_pkg;
	// ==========================================================
	// Array geometry
	localparam int PIXEL_COUNT     = 128;
	localparam int LEAD_DUMMIES    = 2;
	localparam int TRAIL_DUMMIES   = 2;
	localparam int OUTPUT_POSITIONS = LEAD_DUMMIES + PIXEL_COUNT + TRAIL_DUMMIES;
	localparam int PULSES_PER_SCAN = OUTPUT_POSITIONS + 1;
	localparam int RESET_PULSES    = 18;
	// ==========================================================
	// Data path
	localparam int SAMPLE_WIDTH    = 12;
	localparam int POS_WIDTH       = 8;
	localparam int FIFO_DEPTH      = 4;
	localparam logic [SAMPLE_WIDTH-1:0] SAMPLE_RESET = 12'h000;
	// ==========================================================
	// Scan sequencer states
	typedef enum logic [1:0] {
		LPASS_IDLE,
		LPASS_SHIFT,
		LPASS_REINIT
	} lpass_state_t;
endpackage : lpass_pkg

/* File: src/lpass_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on clk; depth must be a power of two.
`timescale 1ns/10ps
module lpass_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
	assign out_valid = wr_ptr != rd_ptr;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : lpass_fifo

/* File: src/lpass_sequencer.sv */
// Scan sequencer for a 128-pixel linear array with a serial start input.
// Assumes the scan clock and start pins arrive asynchronously and are far
// slower than clk; the pixel level comes from an on-chip converter.
// Summary of operation
// - Start bit clocked in starts readout, one position per scan clock.
// - Output two dummies, 128 pixels, two dummies: 132 positions.
// - Integrators held in reset until 18 clocks after the start pulse.
// - Next start pulse ends integration for all pixels.
// - Output goes high impedance after the 132nd position.
// - Start disconnects all sampling capacitors and begins integrator reset.
`timescale 1ns/10ps
module lpass_sequencer
	import lpass_pkg::*;
#(
	parameter int NPIX  = PIXEL_COUNT,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// Scan pins from the controller
	input  wire logic                    scan_start_pin,
	input  wire logic                    scan_clock_pin,
	// Pixel level from the analog front end
	input  wire logic [SAMPLE_WIDTH-1:0] pixel_level,
	// Analog output driver
	output logic      [SAMPLE_WIDTH-1:0] pixel_voltage_out,
	output logic                         pixel_voltage_out_oe,
	// Analog control
	output logic                         integrator_reset,
	output logic                         sample_hold,
	// Sample stream with position tag
	output logic                         stream_valid,
	input  wire logic                    stream_ready,
	output logic      [SAMPLE_WIDTH-1:0] stream_sample,
	output logic      [POS_WIDTH-1:0]    stream_position,
	output logic                         scan_valid
);
	// ==========================================================
	// Pin synchronisers
	logic [2:0]   start_sync;
	logic [2:0]   clk_sync;
	logic         start_level;
	logic         clk_level;
	logic         clk_prev;
	logic         clk_rise;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_sync <= 3'h0;
			clk_sync   <= 3'h0;
		end else begin
			start_sync <= {start_sync[1:0], scan_start_pin};
			clk_sync   <= {clk_sync[1:0], scan_clock_pin};
		end
	end

	// A level counts only once the second and third stages agree.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_level <= 1'b0;
			clk_level   <= 1'b0;
			clk_prev    <= 1'b0;
		end else begin
			if (start_sync[1] == start_sync[2]) begin
				start_level <= start_sync[2];
			end
			if (clk_sync[1] == clk_sync[2]) begin
				clk_level <= clk_sync[2];
			end
			clk_prev <= clk_level;
		end
	end

	assign clk_rise = clk_level && !clk_prev;

	// ==========================================================
	// Shift sequencing
	lpass_state_t state;
	logic [POS_WIDTH-1:0] position;
	logic                 start_taken;
	logic                 primed;
	logic                 fifo_ready;

	// The start level is sampled together with the delayed edge, so both see
	// the same settling; the controller keeps it stable across the edge.
	// start clocked in
	assign start_taken = clk_rise && start_level;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= LPASS_IDLE;
			position <= '0;
		end else begin
			case (state)
				LPASS_IDLE: begin
					if (clk_rise && start_level) begin
						state    <= LPASS_SHIFT;
						position <= 8'h01;
					end
				end
				LPASS_SHIFT: begin
					if (clk_rise && position == POS_WIDTH'(LEAD_DUMMIES + NPIX + TRAIL_DUMMIES)) begin
						state    <= LPASS_REINIT;
						position <= '0;
					end else if (clk_rise) begin
						position <= position + 8'h01;
					end
				end
				LPASS_REINIT: begin
					// last pulse reinitialises
					// Pulse 133 itself did the reinit, so no further scan clock is
					// awaited; waiting for one would swallow the next start.
					state <= LPASS_IDLE;
				end
				default: begin
					state    <= LPASS_IDLE;
					position <= '0;
				end
			endcase
		end
	end

	// Output holds the current position's level; released after the last one.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pixel_voltage_out    <= SAMPLE_RESET;
			pixel_voltage_out_oe <= 1'b0;
		end else begin
			pixel_voltage_out_oe <= (state == LPASS_SHIFT);
			if (state == LPASS_SHIFT) begin
				pixel_voltage_out <= pixel_level;
			end
		end
	end

	// ==========================================================
	// Integration timing
	logic [4:0] reset_count;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			integrator_reset <= 1'b1;
			sample_hold      <= 1'b0;
			reset_count      <= '0;
		end else if (start_taken && state == LPASS_IDLE) begin
			sample_hold      <= 1'b1;
			integrator_reset <= 1'b1;
			reset_count      <= '0;
		end else if (clk_rise && integrator_reset && sample_hold) begin
			if (reset_count == 5'(RESET_PULSES - 1)) begin
				integrator_reset <= 1'b0;
			end
			reset_count <= reset_count + 5'h01;
		end
	end
	// next start ends integration: the branch above re-asserts the hold.

	// Once one full scan has run, the next start gives valid data.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			primed     <= 1'b0;
			scan_valid <= 1'b0;
		end else begin
			if (state == LPASS_REINIT) begin
				primed <= 1'b1;
			end
			if (clk_rise && state == LPASS_IDLE && start_level) begin
				scan_valid <= primed;
			end
		end
	end

	// ==========================================================
	// Tagged sample stream
	logic                  push;
	logic [POS_WIDTH+SAMPLE_WIDTH-1:0] fifo_out;

	// A full FIFO drops the sample; at a 1 MHz scan clock the drain has
	// over a hundred cycles per sample, so this only flags a stuck consumer.
	// tag each position
	assign push = clk_rise && state == LPASS_SHIFT && fifo_ready;

	lpass_fifo #(
		.WIDTH (POS_WIDTH + SAMPLE_WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.in_data   ({position, pixel_level}),
		.out_valid (stream_valid),
		.out_ready (stream_ready),
		.out_data  (fifo_out)
	);

	assign stream_position = fifo_out[POS_WIDTH+SAMPLE_WIDTH-1:SAMPLE_WIDTH];
	assign stream_sample   = fifo_out[SAMPLE_WIDTH-1:0];
endmodule : lpass_sequencer

/* File: verif/lpass_ctrl_model.sv */
// Scan controller model: start pulse, 133 scan clocks, then a rest gap.
// Assumes clk at 125 MHz and go held for two clk cycles.
`timescale 1ns/10ps
module lpass_ctrl_model (
	// Request
	input  wire logic clk,
	input  wire logic go,
	// Scan pins and progress
	output logic       scan_start_pin,
	output logic       scan_clock_pin,
	output logic [7:0] rise_idx,
	output logic       busy
);
	initial {scan_start_pin, scan_clock_pin, busy, rise_idx} = 11'h000;
	always @(posedge clk) begin
		if (go) begin
			busy <= 1'b1;
			scan_start_pin <= 1'b1;
			repeat (62) @(posedge clk);
			for (int i = 0; i < 133; i++) begin
				scan_clock_pin <= 1'b1;
				rise_idx <= 8'(i);
				repeat (31) @(posedge clk);
				scan_start_pin <= 1'b0;
				repeat (31) @(posedge clk);
				scan_clock_pin <= 1'b0;
				repeat (62) @(posedge clk);
			end
			repeat (1250) @(posedge clk);
			busy <= 1'b0;
		end
	end
endmodule : lpass_ctrl_model

/* File: verif/lpass_checker.sv */
// Port checks for the scan sequencer.
// Assumes one clk domain, reset_n async low.
`timescale 1ns/10ps
module lpass_checker
	import lpass_pkg::*;
(
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 reset_n,
	// Scan and stream
	input wire logic                 pixel_voltage_out_oe,
	input wire logic                 integrator_reset,
	input wire logic                 sample_hold,
	input wire logic                 stream_valid,
	input wire logic                 stream_ready,
	input wire logic [POS_WIDTH-1:0] stream_position
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// ====
	// Rises lie at least 8 clk apart, so only lower bounds are safe.
	int oe_len;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			oe_len <= 0;
		else
			oe_len <= pixel_voltage_out_oe ? oe_len + 1 : 0;
	end
	sequence scan_begin;
		$rose(pixel_voltage_out_oe);
	endsequence
	sequence scan_end;
		$fell(pixel_voltage_out_oe);
	endsequence
	start_hold_a: assert property (scan_begin |-> sample_hold && integrator_reset)
		else $error("no hold at start");
	hold_start_a: assert property ($rose(sample_hold) |-> ##[0:2] pixel_voltage_out_oe)
		else $error("stray hold");
	reset_start_a: assert property ($rose(integrator_reset) |-> ##[0:2] pixel_voltage_out_oe)
		else $error("stray reset");
	reset_end_a: assert property ($fell(integrator_reset) |-> oe_len >= 136)
		else $error("early integration");
	scan_len_a: assert property (scan_end |-> oe_len >= 1048)
		else $error("short scan");
	end_state_a: assert property (scan_end |-> !integrator_reset)
		else $error("scan ended in reset");
	head_hold_a: assert property (stream_valid && !stream_ready |=>
		stream_valid && $stable(stream_position))
		else $error("head lost");
	pos_range_a: assert property (stream_valid |-> stream_position inside {[1:132]})
		else $error("bad position");
endmodule : lpass_checker
bind lpass_sequencer lpass_checker chk (.clk, .reset_n, .pixel_voltage_out_oe,
	.integrator_reset, .sample_hold, .stream_valid, .stream_ready, .stream_position);

/* File: verif/tb_top.sv */
// Bench: three scans through the controller model, the last one stalled.
// Assumes package, design, model and checker compiled first.
`timescale 1ns/10ps
module tb_top
	import lpass_pkg::*;
;
	logic clk, reset_n, go, rdy, st, sc, busy, oe, ir, hold, sv, scv, seen_valid, prev;
	logic [SAMPLE_WIDTH-1:0] lvl, smp, pvo;
	logic [POS_WIDTH-1:0]    pos;
	logic [7:0]              ri, ir_rise;
	logic [19:0]             q[$];
	int                      err_total, checks_done;
	lpass_sequencer DUT (.clk, .reset_n, .scan_start_pin(st), .scan_clock_pin(sc),
		.pixel_level(lvl), .pixel_voltage_out(pvo), .pixel_voltage_out_oe(oe),
		.integrator_reset(ir), .sample_hold(hold), .stream_valid(sv), .stream_ready(rdy),
		.stream_sample(smp), .stream_position(pos), .scan_valid(scv));
	lpass_ctrl_model CTRL (.clk, .go, .scan_start_pin(st), .scan_clock_pin(sc),
		.rise_idx(ri), .busy);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	// A stalled scan leaves the stream blocked until the controller rests.
	task automatic run_scan(logic stall, logic [SAMPLE_WIDTH-1:0] v);
		int tail;
		tail = 0;
		q = {};
		{seen_valid, ir_rise, prev} = {1'b0, 8'hFF, ir};
		lvl <= v;
		rdy <= !stall;
		go <= 1'b1;
		repeat (2) @(posedge clk);
		go <= 1'b0;
		// The tail lets a stalled FIFO drain after the controller rests.
		for (int n = 0; busy || n < 4 || tail < 8; n++) begin
			@(posedge clk);
			if (!busy) begin
				rdy <= 1'b1;
				tail++;
			end
			@(negedge clk);
			if (n > 30000) begin
				err_total++;
				stop_test();
			end
			if (prev && !ir)
				ir_rise = ri;
			prev = ir;
			seen_valid |= oe && scv;
			if (sv && rdy)
				q.push_back({smp, pos});
		end
	endtask : run_scan
	task automatic t_scan(logic exp_valid, logic [SAMPLE_WIDTH-1:0] v);
		run_scan(1'b0, v);
		check("count", q.size(), OUTPUT_POSITIONS);
		foreach (q[i]) begin
			check("position", q[i][7:0], i + 1);
			check("sample", q[i][19:8], v);
		end
		check("reset end", ir_rise, RESET_PULSES);
		check("scan valid", seen_valid, exp_valid);
		check("idle oe", oe, 1'b0);
		check("out level", pvo, v);
	endtask : t_scan
	task automatic t_full();
		run_scan(1'b1, 12'h3C3);
		check("kept", q.size(), FIFO_DEPTH);
		foreach (q[i]) check("kept position", q[i][7:0], i + 1);
		check("drained", sv, 1'b0);
	endtask : t_full
	initial begin
		{reset_n, go, rdy, lvl, err_total, checks_done} = '0;
		repeat (12) @(posedge clk);
		check("reset oe", oe, 1'b0);
		check("reset hold", {ir, hold, sv, scv}, 4'h8);
		reset_n <= 1'b1;
		@(posedge clk);
		t_scan(1'b0, 12'h5A5);
		t_scan(1'b1, 12'hA5A);
		t_full();
		stop_test();
	end
endmodule : tb_top
